// *** sfr_read_cmd.sv ***
// Serial flash read-command engine: command capture, array/buffer prefetch, 1/2/4-lane output
`timescale 1ns/1ns
`default_nettype none
`include "sfr_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Command opens at chip select fall; 8-bit opcode then address, all MSB first.
// - 264-byte pages take 15-bit page and 9-bit byte; 256-byte pages 23 bits.
// - Lines 2 and 3 carry quad data only while the quad enable flag is set; the code checks the flag only at opcode decode.
// - Legacy array read takes four dummy bytes, then one bit per clock.
// - An internal address counter advances as data streams out.
// - Continuous reads cross from a page end into the next page, no gap.
// - After the last array byte, reading wraps to page zero without delay.
// - Fastest array read takes two dummy bytes before data.
// - Faster array read takes one dummy byte before data.
// - Slow array read drives data right after the last address bit.
// - Low-power array read behaves like the slow one, no dummy bytes.
// - Single-page read takes four dummy bytes and never touches the buffers.
// - Single-page read wraps to the start of the same page.
// - Buffer one reads with two opcodes, one dummy byte each.
// - Buffer two reads with two opcodes, one dummy byte each.
// - Buffer addresses are 24 bits; only the low 8 or 9 bits index.
// - Dual read: two bits per clock, high bit on line 1, byte per four clocks.
// - Quad read: four bits per clock, bit 7 on line 3, byte per two clocks.
// - Chip select rising ends the read and floats the outputs.
// - Array reads take data from the array and leave both buffers untouched.
////////////////////////////////////////////////////////////////////////////////

module sfr_read_cmd
    import sfr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic io0_in,
    output logic io0_out,
    output logic io0_oe,
    output logic io1_out,
    output logic io1_oe,
    output logic io2_out,
    output logic io2_oe,
    output logic io3_out,
    output logic io3_oe,
    input wire logic quad_enable_flag,
    input wire logic page_size_256,
    output logic mem_rd_en,
    output logic [1:0] mem_target,
    output logic [14:0] mem_page,
    output logic [8:0] mem_byte,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and link clock edges

    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic sck_prev;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 3'h5;
            pin_sync <= 3'h5;
            sck_prev <= 1'b0;
        end else begin
            pin_meta <= {cs_n, sck, io0_in};
            pin_sync <= pin_meta;
            sck_prev <= sck_s;
        end
    end

    // All three pins share one delay, so the host's setup to sck is kept
    assign {cs_n_s, sck_s, si_s} = pin_sync;
    // Mode 0 and mode 3 both sample on rise and shift out on fall
    assign sck_rise = sck_s && !sck_prev && !cs_n_s;
    assign sck_fall = !sck_s && sck_prev && !cs_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // Command capture

    sfr_state_type state;
    sfr_state_type next_state;
    logic [5:0] bit_cnt;
    logic [23:0] rx_shift;
    logic [7:0] rx_byte;
    logic [23:0] addr_full;
    logic opcode_done;
    logic addr_done;
    logic dummy_done;
    logic phase_change;
    logic [2:0] cmd_dummy;
    sfr_target_type cmd_target;
    sfr_wrap_type cmd_wrap;
    sfr_lanes_type cmd_lanes;
    logic [5:0] dummy_last;

    // Bits arrive MSB first, so the newest bit lands at the bottom
    assign rx_byte = {rx_shift[6:0], si_s};
    assign addr_full = {rx_shift[22:0], si_s};
    assign opcode_done = bit_cnt == `SFR_OPCODE_LAST;
    assign addr_done = bit_cnt == `SFR_ADDR_LAST;
    assign dummy_last = {3'(cmd_dummy - 3'h1), 3'h7};
    assign dummy_done = bit_cnt == dummy_last;
    assign phase_change = next_state != state;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode decode

    logic op_legacy;
    logic op_fast_two;
    logic op_fast_one;
    logic op_slow;
    logic op_low_power;
    logic op_page;
    logic op_buf1;
    logic op_buf2;
    logic op_dual;
    logic op_quad;
    logic dec_known;
    logic [2:0] dec_dummy;
    sfr_target_type dec_target;
    sfr_wrap_type dec_wrap;
    sfr_lanes_type dec_lanes;

    assign op_legacy = rx_byte == `SFR_OP_LEGACY;
    assign op_fast_two = rx_byte == `SFR_OP_FAST_TWO;
    assign op_fast_one = rx_byte == `SFR_OP_FAST_ONE;
    assign op_slow = rx_byte == `SFR_OP_SLOW;
    assign op_low_power = rx_byte == `SFR_OP_LOW_POWER;
    assign op_page = rx_byte == `SFR_OP_PAGE;
    assign op_buf1 = rx_byte == `SFR_OP_BUF1_LF || rx_byte == `SFR_OP_BUF1_HF;
    assign op_buf2 = rx_byte == `SFR_OP_BUF2_LF || rx_byte == `SFR_OP_BUF2_HF;
    assign op_dual = rx_byte == `SFR_OP_DUAL;
    // Without the quad enable flag the quad opcode is treated as unknown
    assign op_quad = rx_byte == `SFR_OP_QUAD && quad_enable_flag;

    assign dec_known = op_legacy || op_fast_two || op_fast_one || op_slow || op_low_power
        || op_page || op_buf1 || op_buf2 || op_dual || op_quad;

    assign dec_dummy = (op_legacy || op_page) ? `SFR_DUMMY_FOUR :
        op_fast_two ? `SFR_DUMMY_TWO :
        (op_slow || op_low_power) ? `SFR_DUMMY_NONE :
        `SFR_DUMMY_ONE;

    assign dec_target = op_buf1 ? tgt_buf1 : op_buf2 ? tgt_buf2 : tgt_array;
    assign dec_wrap = op_page ? wrap_page :
        (op_buf1 || op_buf2) ? wrap_buffer : wrap_array;
    assign dec_lanes = op_quad ? lanes_four : op_dual ? lanes_two : lanes_one;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: begin
                if (!cs_n_s) begin
                    next_state = st_opcode;
                end
            end
            st_opcode: begin
                if (sck_rise && opcode_done) begin
                    next_state = dec_known ? st_addr : st_ignore;
                end
            end
            st_addr: begin
                if (sck_rise && addr_done) begin
                    next_state = (cmd_dummy == `SFR_DUMMY_NONE) ? st_data : st_dummy;
                end
            end
            st_dummy: begin
                if (sck_rise && dummy_done) begin
                    next_state = st_data;
                end
            end
            st_data, st_ignore: begin
                next_state = state;
            end
            default: begin
                next_state = st_idle;
            end
        endcase
        // Deselect ends any phase, the host is trusted to hold it low until then
        if (cs_n_s) begin
            next_state = st_idle;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt <= 6'h00;
        end else if (phase_change) begin
            bit_cnt <= 6'h00;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_shift <= 24'h000000;
        end else if (sck_rise && (state == st_opcode || state == st_addr)) begin
            rx_shift <= addr_full;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd_dummy <= `SFR_DUMMY_NONE;
            cmd_target <= tgt_array;
            cmd_wrap <= wrap_array;
            cmd_lanes <= lanes_one;
        end else if (state == st_opcode && sck_rise && opcode_done) begin
            cmd_dummy <= dec_dummy;
            cmd_target <= dec_target;
            cmd_wrap <= dec_wrap;
            cmd_lanes <= dec_lanes;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prefetch from array or buffer

    sfr_stream_if #(.WIDTH(`SFR_FIFO_WIDTH)) fill_if ();
    sfr_stream_if #(.WIDTH(`SFR_FIFO_WIDTH)) drain_if ();

    logic fetch_active;
    logic fetch_pending;
    logic fetch_issue;
    logic load_addr;
    logic [14:0] fetch_page;
    logic [8:0] fetch_byte;
    logic [14:0] start_page;
    logic [8:0] start_byte;
    logic [8:0] last_byte;
    logic byte_at_end;
    logic page_at_end;
    logic [8:0] next_fetch_byte;
    logic [14:0] next_fetch_page;

    assign load_addr = state == st_addr && sck_rise && addr_done;
    // Page bits of a buffer address are don't-care and are passed on unused
    assign start_page = page_size_256 ? addr_full[`SFR_PAGE256_MSB:`SFR_PAGE256_LSB]
        : addr_full[`SFR_PAGE264_MSB:`SFR_PAGE264_LSB];
    assign start_byte = page_size_256 ? {1'b0, addr_full[`SFR_BYTE256_MSB:0]}
        : addr_full[`SFR_BYTE264_MSB:0];
    assign last_byte = page_size_256 ? `SFR_LAST_BYTE_256 : `SFR_LAST_BYTE_264;
    assign byte_at_end = fetch_byte == last_byte;
    assign page_at_end = fetch_page == `SFR_LAST_PAGE;
    // Buffers and the single-page read wrap the byte index in place
    assign next_fetch_byte = byte_at_end ? 9'h000 : fetch_byte + 9'h001;
    assign next_fetch_page = !(byte_at_end && cmd_wrap == wrap_array) ? fetch_page :
        page_at_end ? 15'h0000 : fetch_page + 15'h0001;

    // One read in flight at a time; the free slot checked at issue stays free until the answer
    assign fetch_issue = fetch_active && !fetch_pending && fill_if.ready;
    assign mem_rd_en = fetch_issue;
    assign mem_target = cmd_target;
    assign mem_page = fetch_page;
    assign mem_byte = fetch_byte;
    assign fill_if.valid = mem_rvalid && fetch_active;
    assign fill_if.data = mem_rdata;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fetch_active <= 1'b0;
            fetch_page <= 15'h0000;
            fetch_byte <= 9'h000;
        end else if (cs_n_s) begin
            fetch_active <= 1'b0;
        end else if (load_addr) begin
            // Prefetch starts at once so dummy-less reads have a byte ready
            fetch_active <= 1'b1;
            fetch_page <= start_page;
            fetch_byte <= start_byte;
        end else if (fetch_issue) begin
            fetch_page <= next_fetch_page;
            fetch_byte <= next_fetch_byte;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fetch_pending <= 1'b0;
        end else if (fetch_issue) begin
            fetch_pending <= 1'b1;
        end else if (mem_rvalid) begin
            fetch_pending <= 1'b0;
        end
    end

    sfr_fifo #(
        .WIDTH(`SFR_FIFO_WIDTH),
        .DEPTH(`SFR_FIFO_DEPTH)
    ) u_prefetch (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .flush(cs_n_s),
        .wr(fill_if),
        .rd(drain_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Serial output

    logic [7:0] tx_shift;
    logic [7:0] tx_shifted;
    logic [2:0] slice_cnt;
    logic [2:0] slice_last;
    logic driving;
    logic tx_step;
    logic tx_load;

    assign tx_step = state == st_data && sck_fall;
    assign tx_load = tx_step && slice_cnt == 3'h0;
    assign drain_if.ready = tx_load;
    assign slice_last = cmd_lanes == lanes_four ? `SFR_SLICES_FOUR :
        cmd_lanes == lanes_two ? `SFR_SLICES_TWO : `SFR_SLICES_ONE;
    assign tx_shifted = cmd_lanes == lanes_four ? {tx_shift[3:0], 4'h0} :
        cmd_lanes == lanes_two ? {tx_shift[5:0], 2'h0} : {tx_shift[6:0], 1'b0};

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_shift <= `SFR_IDLE_BYTE;
            slice_cnt <= 3'h0;
            driving <= 1'b0;
        end else if (state != st_data) begin
            slice_cnt <= 3'h0;
            driving <= 1'b0;
        end else if (tx_load) begin
            // A dry buffer shows ones rather than stalling the host's clock
            tx_shift <= drain_if.valid ? drain_if.data : `SFR_IDLE_BYTE;
            slice_cnt <= slice_last;
            driving <= 1'b1;
        end else if (tx_step) begin
            tx_shift <= tx_shifted;
            slice_cnt <= slice_cnt - 3'h1;
        end
    end

    // Lane mapping: the top bit of each slice goes on the highest active line
    assign io1_out = cmd_lanes == lanes_four ? tx_shift[5] : tx_shift[7];
    assign io0_out = cmd_lanes == lanes_four ? tx_shift[4] : tx_shift[6];
    assign io3_out = tx_shift[7];
    assign io2_out = tx_shift[6];
    assign io1_oe = driving;
    assign io0_oe = driving && cmd_lanes != lanes_one;
    assign io2_oe = driving && cmd_lanes == lanes_four;
    assign io3_oe = driving && cmd_lanes == lanes_four;

endmodule

`default_nettype wire

// *** sfr_consts.svh ***
// Constants for the serial flash read-command engine
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// Read opcodes
`define SFR_OP_LEGACY 8'he8
`define SFR_OP_FAST_TWO 8'h1b
`define SFR_OP_FAST_ONE 8'h0b
`define SFR_OP_SLOW 8'h03
`define SFR_OP_LOW_POWER 8'h01
`define SFR_OP_PAGE 8'hd2
`define SFR_OP_BUF1_LF 8'hd1
`define SFR_OP_BUF1_HF 8'hd4
`define SFR_OP_BUF2_LF 8'hd3
`define SFR_OP_BUF2_HF 8'hd6
`define SFR_OP_DUAL 8'h3b
`define SFR_OP_QUAD 8'h6b

// Dummy byte counts
`define SFR_DUMMY_FOUR 3'h4
`define SFR_DUMMY_TWO 3'h2
`define SFR_DUMMY_ONE 3'h1
`define SFR_DUMMY_NONE 3'h0

// Bit counts of the command phases, as index of the last bit
`define SFR_OPCODE_LAST 6'h07
`define SFR_ADDR_LAST 6'h17

// Address field positions
`define SFR_PAGE264_MSB 23
`define SFR_PAGE264_LSB 9
`define SFR_BYTE264_MSB 8
`define SFR_PAGE256_MSB 22
`define SFR_PAGE256_LSB 8
`define SFR_BYTE256_MSB 7

// Array geometry
`define SFR_LAST_PAGE 15'h3fff
`define SFR_LAST_BYTE_264 9'h107
`define SFR_LAST_BYTE_256 9'h0ff

// Output slices per byte, as index of the last slice
`define SFR_SLICES_ONE 3'h7
`define SFR_SLICES_TWO 3'h3
`define SFR_SLICES_FOUR 3'h1

// Byte shown when the prefetch buffer runs dry
`define SFR_IDLE_BYTE 8'hff

// Prefetch buffer shape
`define SFR_FIFO_WIDTH 8
`define SFR_FIFO_DEPTH 8

`endif

// *** sfr_pkg.sv ***
// Types shared by the serial flash read-command engine
package sfr_pkg;

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_opcode = 3'h1,
        st_addr = 3'h3,
        st_dummy = 3'h2,
        st_data = 3'h6,
        st_ignore = 3'h7
    } sfr_state_type;

    typedef enum logic [1:0] {
        tgt_array = 2'h0,
        tgt_buf1 = 2'h1,
        tgt_buf2 = 2'h2
    } sfr_target_type;

    typedef enum logic [1:0] {
        wrap_array = 2'h0,
        wrap_page = 2'h1,
        wrap_buffer = 2'h2
    } sfr_wrap_type;

    typedef enum logic [1:0] {
        lanes_one = 2'h0,
        lanes_two = 2'h1,
        lanes_four = 2'h2
    } sfr_lanes_type;

endpackage

// *** sfr_stream_if.sv ***
// Valid/ready byte stream between the read engine and its prefetch buffer
`timescale 1ns/1ns
`default_nettype none

interface sfr_stream_if #(
    parameter int WIDTH = 8
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// *** sfr_fifo.sv ***
// Prefetch FIFO with flush, valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none

module sfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic flush,
    sfr_stream_if.snk wr,
    sfr_stream_if.src rd
);
    // DEPTH must be a power of two: the pointers wrap by overflow
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign wr.ready = count != FULL_COUNT;
    assign rd.valid = count != '0;
    assign rd.data = store[rd_ptr];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            store[wr_ptr] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

`default_nettype wire

// *** sfr_read_cmd_properties.sv ***
// Port-level assertions for the serial flash read engine
`timescale 1ns/1ns
`default_nettype none

module sfr_read_cmd_properties (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cs_n,
    input wire logic io0_oe,
    input wire logic io1_oe,
    input wire logic io2_oe,
    input wire logic io3_oe,
    input wire logic quad_enable_flag,
    input wire logic page_size_256,
    input wire logic mem_rd_en,
    input wire logic [1:0] mem_target,
    input wire logic [14:0] mem_page,
    input wire logic [8:0] mem_byte
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    logic seen;
    logic [8:0] prev_byte;
    logic [14:0] prev_page;
    logic [1:0] prev_tgt;
    wire any_oe = io0_oe | io1_oe | io2_oe | io3_oe;
    wire [8:0] last_byte = page_size_256 ? 9'h0ff : 9'h107;
    wire prev_last = prev_byte == last_byte;
    wire [8:0] exp_byte = prev_last ? 9'h000 : prev_byte + 9'h001;

    // The first fetch of a command has no predecessor, so deselect forgets it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            seen <= 1'b0;
            prev_byte <= 9'h000;
            prev_page <= 15'h0000;
            prev_tgt <= 2'h0;
        end else if (cs_n) begin
            seen <= 1'b0;
        end else if (mem_rd_en) begin
            seen <= 1'b1;
            prev_byte <= mem_byte;
            prev_page <= mem_page;
            prev_tgt <= mem_target;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_deselect_float: assert property ($rose(cs_n) |-> ##[1:6] !any_oe)
        else $error("lines still driven after deselect");
    a_idle_quiet: assert property (cs_n [*8] |-> !any_oe)
        else $error("line driven while deselected");
    a_quad_gate: assert property (io2_oe |-> quad_enable_flag)
        else $error("line 2 driven without quad enable");
    a_quad_lanes: assert property (io2_oe |-> io3_oe && io1_oe && io0_oe)
        else $error("quad lanes not driven together");
    a_dual_lanes: assert property (io0_oe |-> io1_oe)
        else $error("line 0 driven without line 1");
    a_byte_bound: assert property (mem_rd_en |-> mem_byte <= last_byte)
        else $error("byte index beyond page");
    a_addr_step: assert property (mem_rd_en && seen |-> mem_byte == exp_byte)
        else $error("byte index did not step");
    a_page_hold: assert property (mem_rd_en && seen && !prev_last && mem_target == 2'h0 |->
        mem_page == prev_page && prev_tgt == 2'h0)
        else $error("page or target moved mid page");

    cover property (io2_oe);
    cover property (io0_oe && !io2_oe);
    cover property (mem_rd_en && seen && prev_last);
endmodule

bind sfr_read_cmd sfr_read_cmd_properties sfr_read_cmd_properties_inst (.clk_sys, .rst_b, .cs_n,
    .io0_oe, .io1_oe, .io2_oe, .io3_oe, .quad_enable_flag, .page_size_256, .mem_rd_en, .mem_target,
    .mem_page, .mem_byte);

`default_nettype wire

// *** sfr_host_model.sv ***
// Host link model: chip select, mode 0 serial clock near 125 ns, line sampling
`timescale 1ns/1ns
`default_nettype none

module sfr_host_model (
    output var logic cs_n,
    output var logic sck,
    output var logic io0_drv,
    input wire logic [3:0] io_pin
);
    logic toggle;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        io0_drv = 1'b0;
        toggle = 1'b0;
    end

    // Change in the low phase, sample just before the rise
    task automatic tick(input logic din, output logic [3:0] q);
        io0_drv <= din;
        #62;
        q = io_pin;
        sck <= 1'b1;
        #63;
        sck <= 1'b0;
    endtask

    task automatic begin_cmd(input logic [7:0] op, input logic [23:0] addr, input int nd);
        logic [31:0] w;
        logic [3:0] q;
        w = {op, addr};
        cs_n <= 1'b0;
        #40;
        for (int i = 31; i >= 0; i--) begin
            tick(w[i], q);
        end
        for (int i = 0; i < 8 * nd; i++) begin
            tick(i[0], q);
        end
    endtask

    // Line 0 keeps toggling when not ours, so a stale value never looks right
    task automatic get_byte(input int lanes, output logic [7:0] b);
        logic [3:0] q;
        for (int i = 0; i < 8 / lanes; i++) begin
            toggle = ~toggle;
            tick(toggle, q);
            if (lanes == 1) b = {b[6:0], q[1]};
            else if (lanes == 2) b = {b[5:0], q[1:0]};
            else b = {b[3:0], q};
        end
    endtask

    task automatic end_cmd();
        #40;
        cs_n <= 1'b1;
        #300;
    endtask
endmodule

`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the serial flash read engine
`timescale 1ns/1ns
`default_nettype none
`include "sfr_consts.svh"

module tb_top
    import sfr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic quad_enable_flag = 1'b0;
    logic page_size_256 = 1'b0;
    logic mem_rvalid = 1'b0;
    logic [7:0] mem_rdata = 8'hff;
    logic cs_n, sck, io0_drv;
    logic io0_out, io0_oe, io1_out, io1_oe, io2_out, io2_oe, io3_out, io3_oe, mem_rd_en;
    logic [1:0] mem_target;
    logic [14:0] mem_page;
    logic [8:0] mem_byte;
    int n_errors = 0;
    int n_checks = 0;
    wire pin0 = io0_oe ? io0_out : io0_drv;
    wire [3:0] pins = {io3_oe ? io3_out : 1'bz, io2_oe ? io2_out : 1'bz, io1_oe ? io1_out : 1'bz, pin0};

    always #5 clk_sys = ~clk_sys;

    sfr_read_cmd sfr_read_cmd_inst (.clk_sys, .rst_b, .cs_n, .sck, .io0_in(pin0), .io0_out, .io0_oe,
        .io1_out, .io1_oe, .io2_out, .io2_oe, .io3_out, .io3_oe, .quad_enable_flag, .page_size_256,
        .mem_rd_en, .mem_target, .mem_page, .mem_byte, .mem_rdata, .mem_rvalid);
    sfr_host_model sfr_host_model_inst (.cs_n, .sck, .io0_drv, .io_pin(pins));

    ////////////////////////////////////////////////////////////////////////////////
    // Array and buffer contents; buffers ignore the page field
    function automatic logic [7:0] mdat(input logic [1:0] t, input logic [14:0] p, input logic [8:0] b);
        return {p[3:0], 4'h0} ^ b[7:0] ^ {b[8], t, 5'h00};
    endfunction

    always @(posedge clk_sys) begin
        mem_rvalid <= mem_rd_en;
        if (mem_rd_en) mem_rdata <= mdat(mem_target, mem_target == 2'h0 ? mem_page : 15'h0, mem_byte);
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic set_mode(input logic q, input logic s);
        @(posedge clk_sys);
        quad_enable_flag <= q;
        page_size_256 <= s;
        // Callers read the mode in the same step, so wait for the update to land
        @(posedge clk_sys);
    endtask

    task automatic do_read(input logic [7:0] op, input logic [23:0] a, input int nd, input int lanes,
                           input int n, input logic [1:0] tgt);
        logic [14:0] p;
        logic [8:0] b;
        logic [7:0] got;
        p = tgt != 2'h0 ? 15'h0 : page_size_256 ? a[22:8] : a[23:9];
        b = page_size_256 ? {1'b0, a[7:0]} : a[8:0];
        sfr_host_model_inst.begin_cmd(op, a, nd);
        for (int i = 0; i < n; i++) begin
            sfr_host_model_inst.get_byte(lanes, got);
            chk8(got, mdat(tgt, p, b));
            if (b == (page_size_256 ? 9'h0ff : 9'h107)) begin
                b = 9'h000;
                if (tgt == 2'h0 && op != `SFR_OP_PAGE) p = p == 15'h3fff ? 15'h0 : p + 15'h1;
            end else b = b + 9'h001;
        end
        sfr_host_model_inst.end_cmd();
    endtask

    task automatic do_refused(input logic [7:0] op);
        logic [7:0] got;
        sfr_host_model_inst.begin_cmd(op, 24'h000000, 1);
        sfr_host_model_inst.get_byte(1, got);
        chk8(got, 8'hzz);
        sfr_host_model_inst.end_cmd();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_array_opcodes();
        logic [7:0] ops [5] = '{`SFR_OP_LEGACY, `SFR_OP_FAST_TWO, `SFR_OP_FAST_ONE, `SFR_OP_SLOW,
                                `SFR_OP_LOW_POWER};
        int nd [5] = '{4, 2, 1, 0, 0};
        set_mode(1'b0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            do_read(ops[i], {15'h0123, 9'h106}, nd[i], 1, 4, 2'h0);
        end
        $display("test array opcodes done");
    endtask

    task automatic t_array_wrap();
        set_mode(1'b0, 1'b1);
        do_read(`SFR_OP_FAST_ONE, {1'b0, 15'h3fff, 8'hfe}, 1, 1, 4, 2'h0);
        $display("test array wrap done");
    endtask

    task automatic t_page_read();
        set_mode(1'b0, 1'b0);
        do_read(`SFR_OP_PAGE, {15'h0042, 9'h106}, 4, 1, 4, 2'h0);
        $display("test page read done");
    endtask

    task automatic t_buffers();
        set_mode(1'b0, 1'b1);
        do_read(`SFR_OP_BUF1_LF, 24'hfffffe, 1, 1, 3, 2'h1);
        do_read(`SFR_OP_BUF1_HF, 24'hfffffe, 1, 1, 3, 2'h1);
        do_read(`SFR_OP_BUF2_LF, 24'hfffffe, 1, 1, 3, 2'h2);
        set_mode(1'b0, 1'b0);
        do_read(`SFR_OP_BUF2_HF, 24'hfffe06, 1, 1, 3, 2'h2);
        $display("test buffers done");
    endtask

    task automatic t_wide();
        set_mode(1'b1, 1'b0);
        do_read(`SFR_OP_DUAL, {15'h0007, 9'h106}, 1, 2, 3, 2'h0);
        do_read(`SFR_OP_QUAD, {15'h0010, 9'h0fc}, 1, 4, 20, 2'h0);
        set_mode(1'b0, 1'b0);
        do_refused(`SFR_OP_QUAD);
        $display("test wide lanes done");
    endtask

    task automatic t_unknown();
        do_refused(8'h5a);
        do_read(`SFR_OP_SLOW, {15'h0001, 9'h000}, 0, 1, 2, 2'h0);
        $display("test unknown opcode done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk_sys);
        t_array_opcodes();
        t_array_wrap();
        t_page_read();
        t_buffers();
        t_wide();
        t_unknown();
        give_verdict();
    end

    // The tests need about 14k cycles; allow roughly twice that
    initial begin
        #300000;
        n_errors++;
        give_verdict();
    end
endmodule

`default_nettype wire
